// *** design/tprc_pkg.sv ***
// Purpose: constants and types of the timer prescale, reload and capture/compare register block
// Assumes: 32-bit AXI4-Lite register access, 16-bit timer datapath
// Notes: offsets are byte addresses
package tprc_pkg;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned NUM_CHAN = 4;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] OFF_PRESCALE = 8'h28;
	localparam logic [7:0] OFF_RELOAD = 8'h2C;
	localparam logic [7:0] OFF_CHAN0_CC = 8'h34;
	localparam logic [7:0] OFF_CHAN1_CC = 8'h38;
	localparam logic [7:0] OFF_CHAN2_CC = 8'h3C;
	localparam logic [7:0] OFF_CHAN3_CC = 8'h40;

	// field layout: value in bits 15:0, upper bits reserved
	localparam int unsigned VALUE_LSB = 0;
	localparam int unsigned VALUE_MSB = 15;

	// reset values
	localparam logic [15:0] RST_PRESCALE = 16'h0000;
	localparam logic [15:0] RST_RELOAD = 16'h0000;
	localparam logic [15:0] RST_CC_VALUE = 16'h0000;
	localparam logic [15:0] RESERVED_RD = 16'h0000;

	// bus answers and full-word strobe
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [3:0] STRB_WORD = 4'hF;

	// per-channel control and event from the timer core
	typedef struct packed {
		logic input_mode;
		logic shadow_en;
		logic capture;
	} tprc_chan_ctl_t;

	// axi4-lite request side
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} tprc_axi_req_t;

	// axi4-lite answer side
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tprc_axi_rsp_t;
endpackage : tprc_pkg

// *** design/tprc_timer_regs.sv ***
// Purpose: prescaler with shadow, reload limit and four capture/compare value registers
// Assumes: timer core events arrive on aclk; software uses AXI4-Lite word access
// Notes: all outputs registered
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module tprc_timer_regs #(
	parameter int unsigned CNT_W = tprc_pkg::CNT_W,
	parameter int unsigned NUM_CHAN = tprc_pkg::NUM_CHAN
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire tprc_pkg::tprc_axi_req_t axi_req,
	output tprc_pkg::tprc_axi_rsp_t axi_rsp,
	input wire logic update_event,
	input wire logic [15:0] counter_value,
	input wire tprc_pkg::tprc_chan_ctl_t [3:0] chan_ctl,
	output logic kernel_count_clock,
	output logic [15:0] prescale_active,
	output logic [15:0] reload_limit,
	output logic [3:0][15:0] compare_active,
	output logic [3:0] compare_match
);
	if (CNT_W != 16 || NUM_CHAN != 4) begin : g_check
		$error("tprc_timer_regs supports only a 16-bit counter and four channels");
	end

	logic [15:0] prescale_divider_q;
	logic [15:0] prescale_shadow_q;
	logic [15:0] div_cnt_q;
	logic tick_q;
	logic [15:0] reload_limit_q;
	logic [3:0][15:0] cc_value_q;
	logic [3:0][15:0] cc_active_q;
	logic [3:0] match_q;

	logic awready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	logic wr_fire;
	logic rd_fire;
	logic wr_ok;
	logic wr_hit_psc;
	logic wr_hit_rld;
	logic [3:0] wr_hit_cc;
	logic [15:0] wr_val;
	logic [31:0] rd_data;
	logic rd_hit;

	// write decode
	assign wr_fire = awready_q && axi_req.awvalid && axi_req.wvalid;
	assign wr_ok = axi_req.wstrb == tprc_pkg::STRB_WORD;
	assign wr_val = axi_req.wdata[tprc_pkg::VALUE_MSB:tprc_pkg::VALUE_LSB];
	assign wr_hit_psc = wr_fire && wr_ok && axi_req.awaddr == tprc_pkg::OFF_PRESCALE;
	assign wr_hit_rld = wr_fire && wr_ok && axi_req.awaddr == tprc_pkg::OFF_RELOAD;
	assign wr_hit_cc[0] = wr_fire && wr_ok && axi_req.awaddr == tprc_pkg::OFF_CHAN0_CC;
	assign wr_hit_cc[1] = wr_fire && wr_ok && axi_req.awaddr == tprc_pkg::OFF_CHAN1_CC;
	assign wr_hit_cc[2] = wr_fire && wr_ok && axi_req.awaddr == tprc_pkg::OFF_CHAN2_CC;
	assign wr_hit_cc[3] = wr_fire && wr_ok && axi_req.awaddr == tprc_pkg::OFF_CHAN3_CC;

	// read decode
	assign rd_fire = arready_q && axi_req.arvalid;
	always_comb begin
		rd_hit = 1'b1;
		rd_data = 32'h00000000;
		unique case (axi_req.araddr)
			tprc_pkg::OFF_PRESCALE: rd_data = {tprc_pkg::RESERVED_RD, prescale_divider_q};
			tprc_pkg::OFF_RELOAD: rd_data = {tprc_pkg::RESERVED_RD, reload_limit_q};
			tprc_pkg::OFF_CHAN0_CC: rd_data = {tprc_pkg::RESERVED_RD, cc_value_q[0]};
			tprc_pkg::OFF_CHAN1_CC: rd_data = {tprc_pkg::RESERVED_RD, cc_value_q[1]};
			tprc_pkg::OFF_CHAN2_CC: rd_data = {tprc_pkg::RESERVED_RD, cc_value_q[2]};
			tprc_pkg::OFF_CHAN3_CC: rd_data = {tprc_pkg::RESERVED_RD, cc_value_q[3]};
			default: rd_hit = 1'b0;
		endcase
	end

	// write channel: aw and w taken together
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
		end else begin
			awready_q <= !awready_q && !bvalid_q && axi_req.awvalid && axi_req.wvalid;
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= tprc_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= (wr_ok && (wr_hit_psc || wr_hit_rld || |wr_hit_cc)) ?
				tprc_pkg::RESP_OKAY : tprc_pkg::RESP_SLVERR;
		end else if (bvalid_q && axi_req.bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// read address and data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= tprc_pkg::RESP_OKAY;
		end else begin
			arready_q <= !arready_q && !rvalid_q && axi_req.arvalid;
			if (rd_fire) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_data;
				rresp_q <= rd_hit ? tprc_pkg::RESP_OKAY : tprc_pkg::RESP_SLVERR;
			end else if (rvalid_q && axi_req.rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// prescale setting and its shadow
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prescale_divider_q <= tprc_pkg::RST_PRESCALE;
			prescale_shadow_q <= tprc_pkg::RST_PRESCALE;
		end else begin
			if (wr_hit_psc) begin
				prescale_divider_q <= wr_val;
			end
			if (update_event) begin
				prescale_shadow_q <= prescale_divider_q;
			end
		end
	end

	// divider counter and tick
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end else if (update_event) begin
			div_cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end else if (div_cnt_q == prescale_shadow_q) begin
			div_cnt_q <= 16'h0000;
			tick_q <= 1'b1;
		end else begin
			div_cnt_q <= div_cnt_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// reload limit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reload_limit_q <= tprc_pkg::RST_RELOAD;
		end else if (wr_hit_rld) begin
			reload_limit_q <= wr_val;
		end
	end

	// capture/compare values, capture beats a blocked write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cc_value_q <= {4{tprc_pkg::RST_CC_VALUE}};
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (chan_ctl[i].input_mode) begin
					if (chan_ctl[i].capture) begin
						cc_value_q[i] <= counter_value;
					end
				end else if (wr_hit_cc[i]) begin
					cc_value_q[i] <= wr_val;
				end
			end
		end
	end

	// active compare values
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cc_active_q <= {4{tprc_pkg::RST_CC_VALUE}};
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (!chan_ctl[i].shadow_en || update_event) begin
					cc_active_q[i] <= cc_value_q[i];
				end
			end
		end
	end

	// compare against the counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_q <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				match_q[i] <= !chan_ctl[i].input_mode && counter_value == cc_active_q[i];
			end
		end
	end

	assign axi_rsp.awready = awready_q;
	assign axi_rsp.wready = awready_q;
	assign axi_rsp.bvalid = bvalid_q;
	assign axi_rsp.bresp = bresp_q;
	assign axi_rsp.arready = arready_q;
	assign axi_rsp.rvalid = rvalid_q;
	assign axi_rsp.rdata = rdata_q;
	assign axi_rsp.rresp = rresp_q;
	assign kernel_count_clock = tick_q;
	assign prescale_active = prescale_shadow_q;
	assign reload_limit = reload_limit_q;
	assign compare_active = cc_active_q;
	assign compare_match = match_q;

	// helper: cycles between ticks with no update in between
	logic [16:0] gap_q;
	logic gap_valid_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap_q <= 17'h00000;
			gap_valid_q <= 1'b0;
		end else if (update_event) begin
			gap_q <= 17'h00000;
			gap_valid_q <= 1'b0;
		end else if (tick_q) begin
			gap_q <= 17'h00001;
			gap_valid_q <= 1'b1;
		end else begin
			gap_q <= gap_q + 17'h00001;
		end
	end

	property p_tick_period;
		@(posedge aclk) disable iff (!aresetn)
		(tick_q && gap_valid_q && !update_event) |-> (gap_q == {1'b0, prescale_shadow_q} + 17'h00001);
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("tick spacing differs from setting plus one");

	property p_shadow_only_on_update;
		@(posedge aclk) disable iff (!aresetn)
		!$past(update_event) |-> $stable(prescale_shadow_q);
	endproperty
	a_shadow_only_on_update: assert property (p_shadow_only_on_update) else $error("shadow changed without update");

	property p_shadow_load;
		@(posedge aclk) disable iff (!aresetn)
		update_event |=> prescale_shadow_q == $past(prescale_divider_q);
	endproperty
	a_shadow_load: assert property (p_shadow_load) else $error("shadow not loaded at update");

	property p_reload_write;
		@(posedge aclk) disable iff (!aresetn)
		wr_hit_rld |=> reload_limit_q == $past(wr_val);
	endproperty
	a_reload_write: assert property (p_reload_write) else $error("reload limit write lost");

	property p_read_upper;
		@(posedge aclk) disable iff (!aresetn)
		rvalid_q |-> rdata_q[31:16] == tprc_pkg::RESERVED_RD;
	endproperty
	a_read_upper: assert property (p_read_upper) else $error("reserved read bits not zero");

	property p_prescale_write;
		@(posedge aclk) disable iff (!aresetn)
		wr_hit_psc |=> prescale_divider_q == $past(wr_val);
	endproperty
	a_prescale_write: assert property (p_prescale_write) else $error("prescale write lost");

	property p_bad_strobe;
		@(posedge aclk) disable iff (!aresetn)
		(wr_fire && !wr_ok) |=> bvalid_q && bresp_q == tprc_pkg::RESP_SLVERR;
	endproperty
	a_bad_strobe: assert property (p_bad_strobe) else $error("partial write not refused");

	property p_capture;
		@(posedge aclk) disable iff (!aresetn)
		(chan_ctl[0].input_mode && chan_ctl[0].capture) |=> cc_value_q[0] == $past(counter_value);
	endproperty
	a_capture: assert property (p_capture) else $error("capture value not stored");

	property p_input_readonly;
		@(posedge aclk) disable iff (!aresetn)
		(chan_ctl[1].input_mode && !chan_ctl[1].capture) |=> $stable(cc_value_q[1]);
	endproperty
	a_input_readonly: assert property (p_input_readonly) else $error("input channel value changed by write");

	property p_match;
		@(posedge aclk) disable iff (!aresetn)
		(!chan_ctl[2].input_mode && counter_value == cc_active_q[2]) |=> compare_match[2];
	endproperty
	a_match: assert property (p_match) else $error("compare match missed");

	property p_shadowed_hold;
		@(posedge aclk) disable iff (!aresetn)
		(chan_ctl[3].shadow_en && !update_event) |=> $stable(cc_active_q[3]);
	endproperty
	a_shadowed_hold: assert property (p_shadowed_hold) else $error("shadowed compare changed early");

	property p_divider_clear;
		@(posedge aclk) disable iff (!aresetn)
		update_event |=> div_cnt_q == 16'h0000 && !tick_q;
	endproperty
	a_divider_clear: assert property (p_divider_clear) else $error("divider not cleared on update");

	property p_divider_bound;
		@(posedge aclk) disable iff (!aresetn)
		div_cnt_q <= prescale_shadow_q;
	endproperty
	a_divider_bound: assert property (p_divider_bound) else $error("divider ran past setting");

	property p_compare_direct;
		@(posedge aclk) disable iff (!aresetn)
		!chan_ctl[0].shadow_en |=> cc_active_q[0] == $past(cc_value_q[0]);
	endproperty
	a_compare_direct: assert property (p_compare_direct) else $error("direct compare value not followed");

	property p_output_write;
		@(posedge aclk) disable iff (!aresetn)
		(!chan_ctl[1].input_mode && wr_hit_cc[1]) |=> cc_value_q[1] == $past(wr_val);
	endproperty
	a_output_write: assert property (p_output_write) else $error("output channel write lost");

	property p_input_no_match;
		@(posedge aclk) disable iff (!aresetn)
		chan_ctl[3].input_mode |=> !compare_match[3];
	endproperty
	a_input_no_match: assert property (p_input_no_match) else $error("match flagged in input mode");

	c_write_done: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire ##1 bvalid_q);
	c_read_done: cover property (@(posedge aclk) disable iff (!aresetn) rd_fire ##1 rvalid_q);
	c_slow_tick: cover property (@(posedge aclk) disable iff (!aresetn)
		tick_q && gap_valid_q && prescale_shadow_q == 16'h0002);
	c_capture: cover property (@(posedge aclk) disable iff (!aresetn)
		chan_ctl[0].input_mode && chan_ctl[0].capture);
endmodule : tprc_timer_regs
`default_nettype wire

// *** sim/tb.sv ***
// Purpose: self-checking bench for the prescale, reload and capture/compare register block
// Assumes: AXI4-Lite master tasks, model kept in bench arrays
// Notes: all inputs driven by non-blocking assignment after rising edges
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	tprc_pkg::tprc_axi_req_t req = '0;
	tprc_pkg::tprc_axi_rsp_t rsp;
	logic update_event = 1'b0;
	logic [15:0] counter_value = 16'h0000;
	tprc_pkg::tprc_chan_ctl_t [3:0] chan_ctl = '0;
	logic kernel_count_clock;
	logic [15:0] prescale_active;
	logic [15:0] reload_limit;
	logic [3:0][15:0] compare_active;
	logic [3:0] compare_match;
	int n_fail = 0;
	int checks_done = 0;
	int seed = 67060;
	logic [15:0] m_reg [6];
	logic [15:0] m_shadow = 16'h0000;
	logic [7:0] offs [6] = '{8'h28, 8'h2C, 8'h34, 8'h38, 8'h3C, 8'h40};
	always #12.5 aclk = ~aclk;
	tprc_timer_regs i_tprc_timer_regs (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.update_event(update_event), .counter_value(counter_value), .chan_ctl(chan_ctl),
		.kernel_count_clock(kernel_count_clock), .prescale_active(prescale_active), .reload_limit(reload_limit),
		.compare_active(compare_active), .compare_match(compare_match));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		int n;
		n = 0;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= s;
		req.bready <= 1'b1;
		do begin @(posedge aclk); n++; end while (rsp.awready !== 1'b1 && n < 50);
		req.awvalid <= 1'b0;
		req.wvalid <= 1'b0;
		while (rsp.bvalid !== 1'b1 && n < 50) begin @(posedge aclk); n++; end
		r = rsp.bresp;
		req.bready <= 1'b0;
		if (n >= 50) n_fail++;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin @(posedge aclk); n++; end while (rsp.arready !== 1'b1 && n < 50);
		req.arvalid <= 1'b0;
		while (rsp.rvalid !== 1'b1 && n < 50) begin @(posedge aclk); n++; end
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
		if (n >= 50) n_fail++;
		@(posedge aclk);
	endtask : rd
	task automatic rd_chk(input int i);
		logic [31:0] d;
		logic [1:0] r;
		rd(offs[i], d, r);
		`CHK("rdata", {16'h0000, m_reg[i]}, d)
		`CHK("rresp", tprc_pkg::RESP_OKAY, r)
	endtask : rd_chk
	task automatic wr_chk(input int i, input logic [31:0] d);
		logic [1:0] r;
		wr(offs[i], d, tprc_pkg::STRB_WORD, r);
		`CHK("bresp", tprc_pkg::RESP_OKAY, r)
		if (i < 2 || !chan_ctl[i-2].input_mode) m_reg[i] = d[15:0];
	endtask : wr_chk
	task automatic pulse_update();
		m_shadow = m_reg[0];
		update_event <= 1'b1;
		@(posedge aclk);
		update_event <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask : pulse_update
	task automatic tick_gap(output int g);
		int n;
		n = 0;
		while (kernel_count_clock !== 1'b1 && n < 100) begin @(posedge aclk); n++; end
		g = 0;
		do begin @(posedge aclk); g++; end while (kernel_count_clock !== 1'b1 && g < 100);
	endtask : tick_gap
	initial begin
		#(25ns * 20000);
		n_fail++;
		wrap_up();
	end
	initial begin
		logic [31:0] v;
		logic [31:0] d;
		logic [1:0] r;
		int g;
		for (int i = 0; i < 6; i++) m_reg[i] = 16'h0000;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		tick_gap(g);
		`CHK("gap_reset", 1, g)
		for (int i = 0; i < 6; i++) rd_chk(i);
		for (int k = 0; k < 2; k++) begin
			v = $random(seed);
			wr_chk(0, 32'(v[2:0]) + 32'h0000_0002);
			rd_chk(0);
			`CHK("psc_hold", m_shadow, prescale_active)
			pulse_update();
			`CHK("psc_active", m_reg[0], prescale_active)
			tick_gap(g);
			tick_gap(g);
			`CHK("gap", int'(m_reg[0]) + 1, g)
		end
		wr_chk(0, 32'h0000_0005);
		repeat (2) @(posedge aclk);
		`CHK("psc_unchanged", m_shadow, prescale_active)
		v = $random(seed);
		wr_chk(1, {16'h0000, v[15:0]});
		rd_chk(1);
		`CHK("reload", m_reg[1], reload_limit)
		wr(8'h30, {16'h0000, v[15:0]}, tprc_pkg::STRB_WORD, r);
		`CHK("bresp_unmapped", tprc_pkg::RESP_SLVERR, r)
		rd(8'h30, d, r);
		`CHK("rresp_unmapped", tprc_pkg::RESP_SLVERR, r)
		`CHK("rdata_unmapped", 32'h0000_0000, d)
		wr(offs[1], {16'h0000, ~v[15:0]}, 4'h3, r);
		`CHK("bresp_strobe", tprc_pkg::RESP_SLVERR, r)
		rd_chk(1);
		wr_chk(1, 32'h0000_FFFF);
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			wr_chk(i + 2, {16'h0000, v[15:0]});
			repeat (3) @(posedge aclk);
			`CHK("cmp_direct", v[15:0], compare_active[i])
			counter_value <= v[15:0];
			repeat (2) @(posedge aclk);
			`CHK("match", 1'b1, compare_match[i])
			counter_value <= v[15:0] + 16'h0001;
			repeat (2) @(posedge aclk);
			`CHK("nomatch", 1'b0, compare_match[i])
			chan_ctl[i].shadow_en <= 1'b1;
			wr_chk(i + 2, {16'h0000, ~v[15:0]});
			repeat (3) @(posedge aclk);
			`CHK("cmp_shadow_hold", v[15:0], compare_active[i])
			pulse_update();
			`CHK("cmp_shadow_load", ~v[15:0], compare_active[i])
			rd_chk(i + 2);
			chan_ctl[i].shadow_en <= 1'b0;
			chan_ctl[i].input_mode <= 1'b1;
			v = $random(seed);
			counter_value <= v[15:0];
			@(posedge aclk);
			chan_ctl[i].capture <= 1'b1;
			@(posedge aclk);
			chan_ctl[i].capture <= 1'b0;
			m_reg[i + 2] = counter_value;
			rd_chk(i + 2);
			wr_chk(i + 2, {16'h0000, ~v[15:0]});
			rd_chk(i + 2);
			chan_ctl[i].input_mode <= 1'b0;
			@(posedge aclk);
		end
		wrap_up();
	end
endmodule : tb
`undef CHK
`default_nettype wire
